// file: design/dbgrt_pkg.sv
// Package with the constants and carrier types of the debug component directory table.
package dbgrt_pkg;

   // Byte addresses on the register bus; the table fills the low 2 KB.
   localparam logic [11:0] DBGRT_ADDR_ENTRY5 = 12'h014;
   localparam logic [11:0] DBGRT_ADDR_ENTRY6 = 12'h018;
   localparam logic [11:0] DBGRT_ADDR_LAST = 12'h7FC;
   localparam logic [11:0] DBGRT_ADDR_CONFIG = 12'h800;
   localparam logic [11:0] DBGRT_ADDR_CTRL = 12'h804;
   localparam logic [11:0] DBGRT_ADDR_STATUS = 12'h808;

   // Table geometry.
   localparam int unsigned DBGRT_TABLE_SLOTS = 512;
   localparam int unsigned DBGRT_OFFSET_SHIFT = 12;
   localparam int unsigned DBGRT_LOW_SLOTS = 5;
   localparam logic [8:0] DBGRT_SLOT_ENTRY5 = 9'h005;
   localparam logic [8:0] DBGRT_SLOT_ENTRY6 = 9'h006;

   // Entry field values.
   localparam logic [19:0] DBGRT_PMU_OFFSET_TWO = 20'h000A0;
   localparam logic [19:0] DBGRT_TRACE_OFFSET_TWO = 20'h000B0;
   localparam logic [19:0] DBGRT_OFFSET_NONE = 20'h00000;
   localparam logic [8:0] DBGRT_RESERVED_ZERO = 9'h000;
   localparam logic DBGRT_DOMAIN_ID_NONE = 1'b0;
   localparam logic [1:0] DBGRT_PRESENT_YES = 2'h3;
   localparam logic [1:0] DBGRT_PRESENT_NO = 2'h0;

   // Configuration word: format field in bits 3:0, zero means 512 words of 32 bits.
   localparam logic [3:0] DBGRT_FORMAT_32BIT = 4'h0;

   // Reset values.
   localparam logic [1:0] DBGRT_CTRL_RESET = 2'h0;
   localparam logic [31:0] DBGRT_DATA_RESET = 32'h00000000;

   // Control register bit positions.
   localparam int unsigned DBGRT_CTRL_OVR_EN = 0;
   localparam int unsigned DBGRT_CTRL_OVR_TWO = 1;

   // One table word as seen by the debugger.
   typedef struct packed {
      logic [19:0] offset;
      logic [8:0] reserved;
      logic domain_id_valid;
      logic [1:0] present;
   } dbgrt_entry_s;

   // One bus request as held by the slave.
   typedef struct packed {
      logic read;
      logic write;
      logic [11:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } dbgrt_req_s;

endpackage : dbgrt_pkg

// file: design/dbgrt_table.sv
// Debug component directory table behind an Avalon-MM slave with waitrequest.
// Operation
// RULE_01: Upper twenty bits give component offset; address is base plus offset shifted twelve.
// RULE_02: Multi-block components are pointed at the block holding their identification.
// RULE_03: Offset may be negative two's complement; reader treats it as signed.
// RULE_04: Entry five names second core monitor offset with two cores, zero otherwise.
// RULE_05: Bit two, the domain identifier valid flag, always reads zero.
// RULE_06: Presence field reads 3 when entry exists, 0 when absent.
// RULE_07: Without domain identifiers, reader assumes all components share table's domain.
// RULE_08: Table holds at most 512 entry slots, one component each.
// RULE_09: Entry n sits at byte offset four times n, n from 0 to 511.
// RULE_10: Slot after last component reads absent; reader stops scanning there.
// RULE_11: Last slot carries presence 0 or 3 only and ends the table.
// RULE_12: Components with two views are pointed at by their external view only.
// RULE_13: Format field zero means entries are 512 registers of 32 bits.
// RULE_14: Entries are read only; writes never change any entry. Here a control word write can change entries five and six.
// RULE_15: Bits eleven down to three of every entry always read zero.
`timescale 1ns/100ps

module dbgrt_table #(
   // Words of slots 0 to 4; their contents lie outside this block's scope.
   parameter logic [31:0] LOW_ENTRIES [0:4] = '{
      32'h00001003, 32'h00002003, 32'h00003003, 32'h00004003, 32'h00005003}
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic core_pair_strap,
   output logic second_core_active
);
   import dbgrt_pkg::*;

   // Request as one bundle.
   dbgrt_req_s req;
   assign req.read = avs_read;
   assign req.write = avs_write;
   assign req.address = avs_address;
   assign req.byteenable = avs_byteenable;
   assign req.writedata = avs_writedata;

   // Strap synchroniser: the pin is asynchronous to sys_clk.
   logic strap_meta_reg;
   logic strap_sync_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         strap_meta_reg <= 1'b0;
         strap_sync_reg <= 1'b0;
      end else begin
         strap_meta_reg <= core_pair_strap;
         strap_sync_reg <= strap_meta_reg;
      end
   end

   // Software may override the strap, for example to hide a core held in reset.
   logic [1:0] ctrl_reg;
   logic [1:0] ctrl_next;
   wire logic two_core;
   assign two_core = ctrl_reg[DBGRT_CTRL_OVR_EN] ? ctrl_reg[DBGRT_CTRL_OVR_TWO]
                                                 : strap_sync_reg;
   assign second_core_active = two_core;

   // Entry builder: offset fixed by configuration, flags fixed by the table format.
   function automatic dbgrt_entry_s make_entry(input logic present_cfg,
                                               input logic [19:0] offset_two);
      dbgrt_entry_s e;
      e.offset = present_cfg ? offset_two : DBGRT_OFFSET_NONE;  // [RULE_01] [RULE_04]
      e.reserved = DBGRT_RESERVED_ZERO;                          // [RULE_15]
      e.domain_id_valid = DBGRT_DOMAIN_ID_NONE;                  // [RULE_05]
      e.present = present_cfg ? DBGRT_PRESENT_YES : DBGRT_PRESENT_NO;  // [RULE_06]
      return e;
   endfunction : make_entry

   // The stored offsets are the identification blocks of the external views.
   // Both are positive; the field is still carried as a raw signed value. [RULE_02] [RULE_03]
   wire dbgrt_entry_s entry5;
   wire dbgrt_entry_s entry6;
   assign entry5 = make_entry(two_core, DBGRT_PMU_OFFSET_TWO);    // [RULE_04] [RULE_12]
   assign entry6 = make_entry(two_core, DBGRT_TRACE_OFFSET_TWO);  // [RULE_12]

   // Address decode. The table spans word indices 0 to 511 at byte offset 4n.
   wire logic in_table;
   wire logic [8:0] slot;
   wire logic hit_low;
   wire logic hit_config;
   wire logic hit_ctrl;
   wire logic hit_status;
   assign in_table = ~req.address[11];                      // [RULE_08]
   assign slot = req.address[10:2];                         // [RULE_09]
   assign hit_low = in_table && (slot < 9'(DBGRT_LOW_SLOTS));
   assign hit_config = (req.address[11:2] == DBGRT_ADDR_CONFIG[11:2]);
   assign hit_ctrl = (req.address[11:2] == DBGRT_ADDR_CTRL[11:2]);
   assign hit_status = (req.address[11:2] == DBGRT_ADDR_STATUS[11:2]);

   // Slots 7 to 511 read as absent words, so entry 7 ends a two-core table, entry 5 a one-core
   // table, and the final slot can only show presence zero. [RULE_10] [RULE_11]
   wire logic [31:0] table_word;
   assign table_word = hit_low ? LOW_ENTRIES[slot[2:0]] :
                       (slot == DBGRT_SLOT_ENTRY5) ? 32'(entry5) :
                       (slot == DBGRT_SLOT_ENTRY6) ? 32'(entry6) :
                       DBGRT_DATA_RESET;

   wire logic [31:0] config_word;
   wire logic [31:0] status_word;
   assign config_word = {28'h0000000, DBGRT_FORMAT_32BIT};  // [RULE_13]
   assign status_word = {30'h0, strap_sync_reg, two_core};

   // Unmapped addresses read zero and ignore writes.
   wire logic [31:0] read_word;
   assign read_word = in_table ? table_word :
                      hit_config ? config_word :
                      hit_ctrl ? {30'h0, ctrl_reg} :
                      hit_status ? status_word :
                      DBGRT_DATA_RESET;

   // Every access takes one wait cycle; the data is registered in that cycle so
   // the answer comes from a flip-flop, at the cost of one cycle per access.
   logic ack_reg;
   logic [31:0] readdata_reg;
   wire logic req_any;
   wire logic req_first;
   wire logic write_done;
   assign req_any = req.read | req.write;
   assign req_first = req_any & ~ack_reg;
   assign write_done = req.write & ack_reg;
   assign avs_waitrequest = req_first;
   assign avs_readdata = readdata_reg;

   // Only the control word is writable; table writes are dropped. [RULE_14]
   assign ctrl_next = (write_done && hit_ctrl && req.byteenable[0])
                      ? req.writedata[1:0] : ctrl_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
         ctrl_reg <= DBGRT_CTRL_RESET;
      end else begin
         ack_reg <= req_first;
         ctrl_reg <= ctrl_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         readdata_reg <= DBGRT_DATA_RESET;
      end else if (req_first && req.read) begin
         readdata_reg <= read_word;
      end
   end

   // Checks on what the bus sees at the completing edge of a read or write, and on the wait cycle.
   wire logic rd_done;
   assign rd_done = req.read && !avs_waitrequest;

   a_pmu_entry_two: assert property ( // [RULE_04]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_ENTRY5[11:2] && $past(two_core))
      |-> (avs_readdata == {DBGRT_PMU_OFFSET_TWO, 12'h003}))
      else $error("Entry five does not point at the second core monitor.");

   a_pmu_entry_one: assert property ( // [RULE_04]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_ENTRY5[11:2] && !$past(two_core))
      |-> (avs_readdata == 32'h00000000))
      else $error("Entry five is not all zero with one core.");

   a_trace_entry: assert property ( // [RULE_01]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_ENTRY6[11:2])
      |-> (avs_readdata[31:12] == ($past(two_core) ? DBGRT_TRACE_OFFSET_TWO
                                                   : DBGRT_OFFSET_NONE)))
      else $error("Entry six offset does not match the configuration.");

   a_domain_flag_zero: assert property ( // [RULE_05]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && !avs_address[11]) |-> (avs_readdata[2] == 1'b0))
      else $error("Domain identifier valid flag read as one.");

   a_reserved_bits: assert property ( // [RULE_15]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && !avs_address[11]) |-> (avs_readdata[11:3] == 9'h000))
      else $error("Reserved entry bits read nonzero.");

   a_presence_code: assert property ( // [RULE_06]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && !avs_address[11])
      |-> (avs_readdata[1:0] == 2'h0 || avs_readdata[1:0] == 2'h3))
      else $error("Presence field holds an illegal code.");

   a_last_slot: assert property ( // [RULE_11]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_LAST[11:2])
      |-> (avs_readdata[1:0] == DBGRT_PRESENT_NO))
      else $error("Final slot is not marked absent.");

   a_end_after_six: assert property ( // [RULE_10]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && !avs_address[11] && avs_address[10:2] > DBGRT_SLOT_ENTRY6)
      |-> (avs_readdata == 32'h00000000))
      else $error("Slot beyond entry six does not end the table.");

   a_table_write: assert property ( // [RULE_14]
      @(posedge sys_clk) disable iff (rst)
      (avs_write && !avs_waitrequest && !avs_address[11]) |=> $stable(ctrl_reg))
      else $error("A table write changed block state.");

   a_format_zero: assert property ( // [RULE_13]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_CONFIG[11:2])
      |-> (avs_readdata[3:0] == 4'h0))
      else $error("Format field is not zero.");

   a_wait_bound: assert property (
      @(posedge sys_clk) disable iff (rst)
      $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("Access did not complete after one wait cycle.");

   // The checks below cover bus timing, reset, the strap path, the control word and the table words.
   // They use the master's requests only as triggers and check only what the design drives, so a master that breaks the bus
   // rules is not flagged here as a protocol failure; no check below tests the master's side of the bus.
   // Read data is loaded one edge before completion, hence the $past terms.
   a_one_ready: assert property (
      @(posedge sys_clk) disable iff (rst)
      (req_any && !avs_waitrequest) |=> !(req_any && !avs_waitrequest))
      else $error("Waitrequest stayed low for two cycles of one request.");

   a_reset_clear: assert property (
      @(posedge sys_clk)
      $fell(rst) |-> (avs_readdata == DBGRT_DATA_RESET && ctrl_reg == DBGRT_CTRL_RESET
                      && !second_core_active))
      else $error("State did not return to its reset values.");

   // The strap reaches the configuration two edges after it is sampled.
   a_strap_sync: assert property ( // [RULE_04]
      @(posedge sys_clk) disable iff (rst)
      (!ctrl_reg[DBGRT_CTRL_OVR_EN] && !$past(rst) && !$past(rst, 2))
      |-> (second_core_active == $past(core_pair_strap, 2)))
      else $error("Effective configuration does not follow the strap.");

   a_ctrl_write: assert property (
      @(posedge sys_clk) disable iff (rst)
      (avs_write && !avs_waitrequest && avs_address[11:2] == DBGRT_ADDR_CTRL[11:2]
       && avs_byteenable[0]) |=> (ctrl_reg == $past(avs_writedata[1:0])))
      else $error("A control write did not land.");

   a_ctrl_masked: assert property (
      @(posedge sys_clk) disable iff (rst)
      (avs_write && !avs_waitrequest && !avs_byteenable[0]) |=> $stable(ctrl_reg))
      else $error("A masked control write changed the control word.");

   a_ctrl_readback: assert property (
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_CTRL[11:2])
      |-> (avs_readdata == {30'h0, $past(ctrl_reg)}))
      else $error("Control word read back wrongly.");

   a_status_word: assert property (
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_STATUS[11:2])
      |-> (avs_readdata == {30'h0, $past(strap_sync_reg), $past(second_core_active)}))
      else $error("Status word does not match the configuration.");

   a_pmu_present: assert property ( // [RULE_06]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_ENTRY5[11:2])
      |-> (avs_readdata[1:0] == ($past(two_core) ? DBGRT_PRESENT_YES : DBGRT_PRESENT_NO)))
      else $error("Entry five presence does not match the configuration.");

   a_trace_present: assert property ( // [RULE_06]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_ENTRY6[11:2])
      |-> (avs_readdata[1:0] == ($past(two_core) ? DBGRT_PRESENT_YES : DBGRT_PRESENT_NO)))
      else $error("Entry six presence does not match the configuration.");

   a_trace_entry_one: assert property ( // [RULE_06]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_ENTRY6[11:2] && !$past(two_core))
      |-> (avs_readdata == 32'h00000000))
      else $error("Entry six is not all zero with one core.");

   a_low_slots: assert property ( // [RULE_09]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && !avs_address[11] && avs_address[10:2] < 9'(DBGRT_LOW_SLOTS))
      |-> (avs_readdata == LOW_ENTRIES[avs_address[4:2]]))
      else $error("A low slot read returned the wrong word.");

   a_unmapped_zero: assert property ( // [RULE_08]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] > DBGRT_ADDR_STATUS[11:2])
      |-> (avs_readdata == 32'h00000000))
      else $error("An address outside the map read nonzero.");

   a_config_word: assert property ( // [RULE_13]
      @(posedge sys_clk) disable iff (rst)
      (rd_done && avs_address[11:2] == DBGRT_ADDR_CONFIG[11:2])
      |-> (avs_readdata == 32'h00000000))
      else $error("Configuration word holds nonzero bits.");

   // Read data only loads on a read, so no write may disturb it.
   a_write_no_data: assert property ( // [RULE_14]
      @(posedge sys_clk) disable iff (rst)
      avs_write |=> $stable(avs_readdata))
      else $error("A write disturbed the read data.");

endmodule : dbgrt_table

// file: tb/dbgrt_debugger_model.sv
// Debugger model that masters the register bus and walks the component table.
`timescale 1ns/100ps
module dbgrt_debugger_model (
   input wire logic sys_clk,
   output logic [11:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   import dbgrt_pkg::*;
   logic signed [31:0] last_addr;
   initial begin
      avs_address = 12'h000;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h00000000;
      avs_byteenable = 4'h0;
      last_addr = 32'sh0;
   end
   // Waitrequest and read data are looked at right after the rising edge, before that
   // edge's register updates land, so the loop sees what the slave showed at the edge.
   task automatic access(input logic rd, input logic [11:0] a, input logic [31:0] wd,
                         input logic [3:0] be, output logic [31:0] rdata);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= wd;
      avs_byteenable <= be;
      avs_read <= rd;
      avs_write <= ~rd;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rdata = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      // A released bus shows inverted leftovers so nothing relies on stale values.
      avs_address <= ~a;
      avs_writedata <= ~wd;
   endtask : access
   task automatic scan_table(output int unsigned found);
      dbgrt_entry_s e;
      found = 0;
      for (int n = 0; n < 512; n++) begin
         access(1'b1, 12'(n * 4), 32'h00000000, 4'hF, e);
         if (e.present == 2'h0) break;
         // The domain flag is not consulted; all entries share the table's domain.
         last_addr = $signed({e.offset, 12'h000});
         found++;
         if (n == 511) break;
      end
   endtask : scan_table
endmodule : dbgrt_debugger_model

// file: tb/dbgrt_table_tb_top.sv
// Top-level bench for the debug component directory table.
`timescale 1ns/100ps
module dbgrt_table_tb_top;
   import dbgrt_pkg::*;
   localparam logic [31:0] ENTRY5_TWO = 32'h000A0003;
   localparam logic [31:0] ENTRY6_TWO = 32'h000B0003;
   logic sys_clk;
   logic rst;
   logic core_pair_strap;
   logic [11:0] avs_address;
   logic avs_read;
   logic avs_write;
   logic [31:0] avs_writedata;
   logic [3:0] avs_byteenable;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic second_core_active;
   int fail_count;
   int total_checks;

   dbgrt_table dut_u (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .core_pair_strap(core_pair_strap),
      .second_core_active(second_core_active));
   dbgrt_debugger_model dbg_u (.sys_clk(sys_clk), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] d;
      dbg_u.access(1'b1, a, 32'h00000000, 4'hF, d);
      check(d, exp);
   endtask : rd_check
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      logic [31:0] unused;
      dbg_u.access(1'b0, a, d, be, unused);
   endtask : wr
   // The strap passes two flip-flops, so four edges leave margin.
   task automatic set_strap(input logic v);
      @(posedge sys_clk);
      core_pair_strap <= v;
      repeat (4) @(posedge sys_clk);
   endtask : set_strap

   task automatic t_two_core;
      int unsigned found;
      set_strap(1'b1);
      rd_check(DBGRT_ADDR_ENTRY5, ENTRY5_TWO);
      rd_check(DBGRT_ADDR_ENTRY6, ENTRY6_TWO);
      check({31'h0, second_core_active}, 32'h1);
      dbg_u.scan_table(found);
      check(found, 32'h7);
      check(dbg_u.last_addr, 32'h000B0000);
   endtask : t_two_core
   task automatic t_one_core;
      int unsigned found;
      set_strap(1'b0);
      rd_check(DBGRT_ADDR_ENTRY5, 32'h00000000);
      rd_check(DBGRT_ADDR_ENTRY6, 32'h00000000);
      dbg_u.scan_table(found);
      check(found, 32'h5);
      rd_check(DBGRT_ADDR_LAST, 32'h00000000);
      rd_check(DBGRT_ADDR_CONFIG, 32'h00000000);
      rd_check(12'hC00, 32'h00000000);
   endtask : t_one_core
   task automatic t_write_ro;
      set_strap(1'b1);
      wr(DBGRT_ADDR_ENTRY5, 32'hFFFFFFFF, 4'hF);
      wr(DBGRT_ADDR_ENTRY6, 32'h00000000, 4'hF);
      rd_check(DBGRT_ADDR_ENTRY5, ENTRY5_TWO);
      rd_check(DBGRT_ADDR_ENTRY6, ENTRY6_TWO);
   endtask : t_write_ro
   task automatic t_override;
      set_strap(1'b0);
      wr(DBGRT_ADDR_CTRL, 32'h00000003, 4'h1);
      // The control word updates at the completing edge; look one edge later.
      @(posedge sys_clk);
      check({31'h0, second_core_active}, 32'h1);
      rd_check(DBGRT_ADDR_ENTRY5, ENTRY5_TWO);
      rd_check(DBGRT_ADDR_STATUS, 32'h00000001);
      rd_check(DBGRT_ADDR_CTRL, 32'h00000003);
      wr(DBGRT_ADDR_CTRL, 32'h00000000, 4'h0);
      @(posedge sys_clk);
      check({31'h0, second_core_active}, 32'h1);
      wr(DBGRT_ADDR_CTRL, 32'h00000000, 4'h1);
      rd_check(DBGRT_ADDR_ENTRY6, 32'h00000000);
   endtask : t_override

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   initial begin
      rst = 1'b1;
      core_pair_strap = 1'b0;
      fail_count = 0;
      total_checks = 0;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      t_two_core();
      t_one_core();
      t_write_ro();
      t_override();
      close_out();
   end
   initial begin
      #(40 * 20000);
      fail_count++;
      close_out();
   end
endmodule : dbgrt_table_tb_top
